// >>> shared/swcfg_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SWCFG_MAP_SVH
`define SWCFG_MAP_SVH
`define OFF_TX_MARGIN 8'h94
`define OFF_OPMODE 8'h98
`define OFF_DS_PME 8'h9C
`define OFF_ROM_CTRL 8'hA0
`define OFF_ROM_ADDR_DATA 8'hA4
`define TX_MARGIN_RST 16'h116B
`define OPMODE_505 16'h0182
`define OPMODE_606 16'h01E2
`define OPMODE_508 16'h01C2
`define CLKBUF_EN_606 7'h7F
`define CLKBUF_EN_OTHER 7'h5F
`define LP_OPTION_RST 4'h0
`define ROM_RATE_RST 2'h1
`define ROM_RATE_TEST 2'h3
`define ROM_DIV_NORMAL 7'h40
`define ROM_DIV_TEST 7'h02
`define ROM_OP_WRSR 8'h01
`define ROM_OP_WRITE 8'h02
`define ROM_OP_READ 8'h03
`define ROM_OP_WRDI 8'h04
`define ROM_OP_RDSR 8'h05
`define ROM_OP_WREN 8'h06
`define ROM_LEN_OP 6'h07
`define ROM_LEN_STATUS 6'h0F
`define ROM_LEN_WORD 6'h27
`define AL_LAST_WORD 2'h2
`define AL_BLANK 16'hFFFF
`define PME_CAP_BIT 0
`define PME_TURNOFF_BIT 1
`define PME_POWER_BIT 2
`define PME_RESET_BIT 3
`endif

// >>> shared/swcfg_pkg.sv
// Types shared by the configuration register bank
package swcfg_pkg;
  typedef enum logic [1:0] {
    CFG_505 = 2'h0,
    CFG_606 = 2'h1,
    CFG_508 = 2'h2,
    CFG_RSVD = 2'h3
  } port_config_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOW = 2'h1,
    ST_HIGH = 2'h3,
    ST_END = 2'h2
  } rom_state_t;
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_WRSR = 3'h1,
    CMD_WRITE = 3'h2,
    CMD_READ = 3'h3,
    CMD_WRDI = 3'h4,
    CMD_RDSR = 3'h5,
    CMD_WREN = 3'h6,
    CMD_RSVD = 3'h7
  } rom_cmd_t;
endpackage

// >>> logic/ds_port_pme.sv
// Per downstream port power-management event register and pins
`include "swcfg_map.svh"
module ds_port_pme (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [3:0] wdata,
  input wire logic cap_load,
  input wire logic cap_val,
  input wire logic [1:0] link_state,
  output logic [31:0] value,
  output logic pme_turnoff_req,
  output logic gpio_out,
  output logic gpio_oe,
  output logic attached_reset_n
);
  typedef struct packed {
    logic cap;
    logic turnoff;
    logic power;
    logic rst_bit;
    logic [1:0] link;
  } pme_state_t;

  pme_state_t s_q;
  pme_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (cap_load) begin
      s_d.cap = cap_val;
    end
    if (wr_en) begin
      s_d.turnoff = wdata[`PME_TURNOFF_BIT];
      s_d.power = wdata[`PME_POWER_BIT];
      s_d.rst_bit = wdata[`PME_RESET_BIT];
    end
    s_d.link = link_state;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '{cap: 1'b1, turnoff: 1'b0, power: 1'b1, rst_bit: 1'b1,
               link: 2'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign value = {14'h0000, s_q.link, 12'h000, s_q.rst_bit, s_q.power,
                  s_q.turnoff, s_q.cap};
  assign pme_turnoff_req = s_q.turnoff;
  assign gpio_oe = s_q.cap;
  assign gpio_out = s_q.power;
  assign attached_reset_n = s_q.rst_bit;

  a_turnoff_write: assert property (@(posedge clk) disable iff (rst)
    wr_en |=> pme_turnoff_req == $past(wdata[`PME_TURNOFF_BIT]))
    else $error("turn-off request did not follow the write");
  a_reset_follow: assert property (@(posedge clk) disable iff (rst)
    wr_en && !wdata[`PME_RESET_BIT] |=> !attached_reset_n)
    else $error("attached reset not asserted after clearing bit");
  a_link_track: assert property (@(posedge clk) disable iff (rst)
    ##1 value[17:16] == $past(link_state))
    else $error("link status not tracking the attached link");
endmodule // ds_port_pme

// >>> logic/switch_port_config_eeprom_regs.sv
// Vendor configuration registers with serial ROM command engine
`include "swcfg_map.svh"
module switch_port_config_eeprom_regs #(
  parameter int NUM_DS = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_req,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [2:0] cfg_port,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire logic [1:0] port_config,
  input wire logic refclk_buffer_powerdown_strap,
  output logic [6:0] refclk_output_enable,
  input wire logic [2*NUM_DS-1:0] ds_link_state,
  output logic [NUM_DS-1:0] pme_turnoff_req,
  output logic [NUM_DS-1:0] gpio_out,
  output logic [NUM_DS-1:0] gpio_oe,
  output logic [NUM_DS-1:0] ds_reset_n,
  output logic rom_sck,
  output logic rom_cs_n,
  output logic rom_mosi,
  input wire logic rom_miso
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    swcfg_pkg::port_config_t pcfg;
    logic [15:0] opmode;
    logic [15:0] tx_margin;
    logic refclk_pd;
    logic [6:0] clkbuf_en;
    logic [6:0] refclk_en;
    logic start;
    logic [2:0] cmd;
    logic al_status;
    logic al_dis;
    logic [1:0] rate;
    logic wip;
    logic wel;
    logic bp0;
    logic bp1;
    logic [2:0] st_hi;
    logic wpen;
    logic [15:0] rom_addr;
    logic [15:0] rom_data;
    swcfg_pkg::rom_state_t fsm;
    logic [5:0] div;
    logic [5:0] bits;
    logic [39:0] sho;
    logic [15:0] shi;
    logic sck;
    logic cs_n;
    logic mosi;
    logic xfer_al;
    logic al_busy;
    logic al_tried;
    logic al_ok;
    logic [1:0] al_idx;
    logic cap_load;
    logic [NUM_DS-1:0] cap_val;
    logic ack;
    logic [31:0] rdata;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  top_state_t s_rst;

  logic [NUM_DS-1:0][31:0] ds_val;
  logic [NUM_DS-1:0] ds_wr;
  logic wr;
  logic up;
  logic [31:0] wm;
  logic [6:0] divr;
  logic [5:0] half_m1;
  logic [39:0] frame;
  logic [5:0] flen;
  logic [7:0] sr_byte;
  logic cmd_ok;
  logic [2:0] ds_idx;

  function automatic logic [15:0] opmode_of(swcfg_pkg::port_config_t c);
    case (c)
      swcfg_pkg::CFG_606: opmode_of = `OPMODE_606;
      swcfg_pkg::CFG_508: opmode_of = `OPMODE_508;
      default: opmode_of = `OPMODE_505;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Reset image; straps sampled while reset is held
  // ------------------------------------------------------------------
  always_comb begin
    s_rst = '0;
    s_rst.pcfg = swcfg_pkg::port_config_t'(port_config);
    s_rst.opmode = opmode_of(s_rst.pcfg);
    s_rst.tx_margin = `TX_MARGIN_RST;
    s_rst.refclk_pd = refclk_buffer_powerdown_strap;
    s_rst.clkbuf_en = (s_rst.pcfg == swcfg_pkg::CFG_606) ?
                      `CLKBUF_EN_606 : `CLKBUF_EN_OTHER;
    s_rst.refclk_en = s_rst.clkbuf_en & {7{~s_rst.refclk_pd}};
    s_rst.al_dis = 1'b1;
    s_rst.rate = `ROM_RATE_RST;
    s_rst.fsm = swcfg_pkg::ST_IDLE;
    s_rst.cs_n = 1'b1;
  end

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ack = cfg_req;
    s_d.cap_load = 1'b0;
    wr = cfg_req & cfg_wr;
    up = (cfg_port == 3'h0);
    wm = {{8{cfg_byte_en[3]}}, {8{cfg_byte_en[2]}},
          {8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}};
    ds_idx = cfg_port - 3'h1;

    // Serial clock half period; reserved codes fall back to /64
    divr = (s_q.rate == `ROM_RATE_TEST) ? `ROM_DIV_TEST
                                         : `ROM_DIV_NORMAL;
    half_m1 = divr[6:1] - 6'h01;

    // Frame for the command in IDLE: software or autoload read
    sr_byte = {s_q.wpen, 3'h0, s_q.bp1, s_q.bp0, 2'h0};
    frame = '0;
    flen = `ROM_LEN_OP;
    cmd_ok = 1'b1;
    if (s_q.al_busy) begin
      frame = {`ROM_OP_READ, 14'h0000, s_q.al_idx, 16'h0000};
      flen = `ROM_LEN_WORD;
    end else begin
      case (s_q.cmd)
        swcfg_pkg::CMD_WRSR: begin
          frame = {`ROM_OP_WRSR, sr_byte, 24'h000000};
          flen = `ROM_LEN_STATUS;
        end
        swcfg_pkg::CMD_WRITE: begin
          frame = {`ROM_OP_WRITE, s_q.rom_addr, s_q.rom_data};
          flen = `ROM_LEN_WORD;
        end
        swcfg_pkg::CMD_READ: begin
          frame = {`ROM_OP_READ, s_q.rom_addr, 16'h0000};
          flen = `ROM_LEN_WORD;
        end
        swcfg_pkg::CMD_WRDI: frame = {`ROM_OP_WRDI, 32'h00000000};
        swcfg_pkg::CMD_RDSR: begin
          frame = {`ROM_OP_RDSR, 32'h00000000};
          flen = `ROM_LEN_STATUS;
        end
        swcfg_pkg::CMD_WREN: frame = {`ROM_OP_WREN, 32'h00000000};
        default: cmd_ok = 1'b0;
      endcase
    end

    // Software writes; read-only and reserved bits are untouched
    if (wr && up && cfg_addr == `OFF_ROM_CTRL) begin
      if (wm[0]) begin
        // Command is frozen while a cycle is pending or running
        if (!s_q.start && s_q.fsm == swcfg_pkg::ST_IDLE) begin
          s_d.start = cfg_wdata[0];
          s_d.cmd = cfg_wdata[3:1];
        end
        s_d.al_dis = cfg_wdata[5];
        s_d.rate = cfg_wdata[7:6];
      end
      if (wm[8]) begin
        s_d.bp0 = cfg_wdata[10];
        s_d.bp1 = cfg_wdata[11];
        s_d.wpen = cfg_wdata[15];
      end
    end
    if (wr && up && cfg_addr == `OFF_ROM_ADDR_DATA) begin
      s_d.rom_addr = (s_q.rom_addr & ~wm[15:0]) |
                     (cfg_wdata[15:0] & wm[15:0]);
      s_d.rom_data = (s_q.rom_data & ~wm[31:16]) |
                     (cfg_wdata[31:16] & wm[31:16]);
    end

    // Serial engine
    case (s_q.fsm)
      swcfg_pkg::ST_IDLE: begin
        s_d.sck = 1'b0;
        s_d.cs_n = 1'b1;
        if (s_q.al_busy || (s_q.start && cmd_ok)) begin
          s_d.xfer_al = s_q.al_busy;
          s_d.cs_n = 1'b0;
          s_d.sho = frame;
          s_d.mosi = frame[39];
          s_d.bits = flen;
          s_d.div = half_m1;
          s_d.fsm = swcfg_pkg::ST_LOW;
        end else if (s_q.start) begin
          s_d.start = 1'b0;
        end else if (!s_q.al_dis && !s_q.al_tried) begin
          s_d.al_busy = 1'b1;
          s_d.al_tried = 1'b1;
          s_d.al_idx = 2'h0;
        end
      end
      swcfg_pkg::ST_LOW: begin
        if (s_q.div == 6'h00) begin
          s_d.sck = 1'b1;
          s_d.shi = {s_q.shi[14:0], rom_miso};
          s_d.div = half_m1;
          s_d.fsm = swcfg_pkg::ST_HIGH;
        end else begin
          s_d.div = s_q.div - 6'h01;
        end
      end
      swcfg_pkg::ST_HIGH: begin
        if (s_q.div == 6'h00) begin
          s_d.sck = 1'b0;
          if (s_q.bits == 6'h00) begin
            s_d.fsm = swcfg_pkg::ST_END;
          end else begin
            s_d.sho = {s_q.sho[38:0], 1'b0};
            s_d.mosi = s_q.sho[38];
            s_d.bits = s_q.bits - 6'h01;
            s_d.div = half_m1;
            s_d.fsm = swcfg_pkg::ST_LOW;
          end
        end else begin
          s_d.div = s_q.div - 6'h01;
        end
      end
      swcfg_pkg::ST_END: begin
        s_d.cs_n = 1'b1;
        s_d.mosi = 1'b0;
        s_d.fsm = swcfg_pkg::ST_IDLE;
        if (s_q.xfer_al) begin
          // Blank first word marks an unprogrammed ROM: keep defaults
          case (s_q.al_idx)
            2'h0: begin
              s_d.al_ok = (s_q.shi != `AL_BLANK);
              if (s_q.shi != `AL_BLANK) begin
                s_d.tx_margin = s_q.shi;
              end
            end
            2'h1: begin
              if (s_q.al_ok) begin
                s_d.refclk_pd = s_q.shi[7];
                s_d.clkbuf_en = s_q.shi[6:0];
              end
            end
            default: begin
              s_d.cap_load = s_q.al_ok;
              s_d.cap_val = s_q.shi[NUM_DS-1:0];
            end
          endcase
          if (s_q.al_idx == `AL_LAST_WORD) begin
            s_d.al_busy = 1'b0;
            s_d.al_status = s_q.al_ok;
          end else begin
            s_d.al_idx = s_q.al_idx + 2'h1;
          end
        end else begin
          s_d.start = 1'b0;
          if (s_q.cmd == swcfg_pkg::CMD_READ) begin
            s_d.rom_data = s_q.shi;
          end
          if (s_q.cmd == swcfg_pkg::CMD_RDSR) begin
            s_d.wip = s_q.shi[0];
            s_d.wel = s_q.shi[1];
            s_d.st_hi = s_q.shi[6:4];
          end
        end
      end
      default: s_d.fsm = swcfg_pkg::ST_IDLE;
    endcase

    s_d.refclk_en = s_d.clkbuf_en & {7{~s_d.refclk_pd}};

    // Read data; unmapped offsets and reserved bits read zero
    s_d.rdata = 32'h00000000;
    if (cfg_req && !cfg_wr) begin
      if (up) begin
        case (cfg_addr)
          `OFF_TX_MARGIN: s_d.rdata = {16'h0000, s_q.tx_margin};
          `OFF_OPMODE: s_d.rdata = {4'h0, `LP_OPTION_RST, s_q.refclk_pd,
                                    s_q.clkbuf_en, s_q.opmode};
          `OFF_ROM_CTRL: s_d.rdata = {16'h0000, s_q.wpen, s_q.st_hi,
                                      s_q.bp1, s_q.bp0, s_q.wel, s_q.wip,
                                      s_q.rate, s_q.al_dis, s_q.al_status,
                                      s_q.cmd, s_q.start};
          `OFF_ROM_ADDR_DATA: s_d.rdata = {s_q.rom_data, s_q.rom_addr};
          default: s_d.rdata = 32'h00000000;
        endcase
      end else if (cfg_addr == `OFF_DS_PME && ds_idx < 3'(NUM_DS)) begin
        s_d.rdata = ds_val[ds_idx];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= s_rst;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // Downstream ports
  // ------------------------------------------------------------------
  for (genvar i = 0; i < NUM_DS; i++) begin : g_ds
    assign ds_wr[i] = wr && cfg_byte_en[0] && cfg_addr == `OFF_DS_PME &&
                      cfg_port == 3'(i + 1);
    ds_port_pme u_pme (
      .clk(clk),
      .rst(rst),
      .wr_en(ds_wr[i]),
      .wdata(cfg_wdata[3:0]),
      .cap_load(s_q.cap_load),
      .cap_val(s_q.cap_val[i]),
      .link_state(ds_link_state[2*i+1:2*i]),
      .value(ds_val[i]),
      .pme_turnoff_req(pme_turnoff_req[i]),
      .gpio_out(gpio_out[i]),
      .gpio_oe(gpio_oe[i]),
      .attached_reset_n(ds_reset_n[i])
    );
  end

  assign cfg_ack = s_q.ack;
  assign cfg_rdata = s_q.rdata;
  assign refclk_output_enable = s_q.refclk_en;
  assign rom_sck = s_q.sck;
  assign rom_cs_n = s_q.cs_n;
  assign rom_mosi = s_q.mosi;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_margin_readonly: assert property (@(posedge clk) disable iff (rst)
    wr && cfg_addr == `OFF_TX_MARGIN && !s_q.al_busy |=>
    $stable(s_q.tx_margin))
    else $error("transmit margin changed by a write");
  a_opmode_strap: assert property (@(posedge clk) disable iff (rst)
    s_q.opmode == opmode_of(s_q.pcfg) && $stable(s_q.opmode))
    else $error("strap field does not match port configuration");
  a_refclk_gate: assert property (@(posedge clk) disable iff (rst)
    s_q.refclk_pd |-> refclk_output_enable == 7'h00)
    else $error("clock outputs enabled while powered down");
  a_start_launch: assert property (@(posedge clk) disable iff (rst)
    s_q.fsm == swcfg_pkg::ST_IDLE && s_q.start && cmd_ok &&
    !s_q.al_busy |=> !rom_cs_n && s_q.sho[39:32] == $past(frame[39:32]))
    else $error("command did not launch a serial cycle");
  a_opcode_match: assert property (@(posedge clk) disable iff (rst)
    $fell(rom_cs_n) && !s_q.xfer_al |->
    s_q.sho[39:32] == {5'h00, s_q.cmd})
    else $error("opcode differs from command field");
  a_autoload_skip: assert property (@(posedge clk) disable iff (rst)
    s_q.al_dis && !s_q.al_busy |=> !s_q.al_busy)
    else $error("autoload started while disabled");
  a_status_done: assert property (@(posedge clk) disable iff (rst)
    $rose(s_q.al_status) |-> $fell(s_q.al_busy))
    else $error("autoload status set outside autoload completion");
  a_sck_low: assert property (@(posedge clk) disable iff (rst)
    $fell(rom_sck) && s_q.rate == `ROM_RATE_RST &&
    s_q.fsm == swcfg_pkg::ST_LOW |-> !rom_sck[*8])
    else $error("serial clock low phase too short");
  a_status_mirror: assert property (@(posedge clk) disable iff (rst)
    s_q.fsm == swcfg_pkg::ST_END && !s_q.xfer_al &&
    s_q.cmd == swcfg_pkg::CMD_RDSR |=>
    s_q.wip == $past(s_q.shi[0]) && s_q.wel == $past(s_q.shi[1]))
    else $error("status bits not updated by read-status");
  a_read_return: assert property (@(posedge clk) disable iff (rst)
    s_q.fsm == swcfg_pkg::ST_END && !s_q.xfer_al &&
    s_q.cmd == swcfg_pkg::CMD_READ |=> s_q.rom_data == $past(s_q.shi))
    else $error("read data not returned");
  a_start_clear: assert property (@(posedge clk) disable iff (rst)
    s_q.fsm == swcfg_pkg::ST_END && !s_q.xfer_al |=> !s_q.start ##1
    rom_cs_n)
    else $error("start bit not cleared at cycle end");
  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    cfg_req && !cfg_wr && cfg_addr == `OFF_ROM_CTRL |=>
    cfg_ack && cfg_rdata[31:16] == 16'h0000)
    else $error("reserved control bits read nonzero");

  c_rom_read: cover property (@(posedge clk) disable iff (rst)
    s_q.fsm == swcfg_pkg::ST_END && s_q.cmd == swcfg_pkg::CMD_READ);
  c_rom_wrsr: cover property (@(posedge clk) disable iff (rst)
    $fell(rom_cs_n) && s_q.cmd == swcfg_pkg::CMD_WRSR);
  c_autoload_ok: cover property (@(posedge clk) disable iff (rst)
    $rose(s_q.al_status));
  c_ds_write: cover property (@(posedge clk) disable iff (rst)
    |ds_wr);
endmodule // switch_port_config_eeprom_regs

// >>> verification/serial_rom_model.sv
// Behavioural serial ROM answering the command engine, mode 0, MSB first
module serial_rom_model (
  input wire logic rom_sck,
  input wire logic rom_cs_n,
  input wire logic rom_mosi,
  output logic rom_miso
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:3];
  logic [15:0] adr, dat;
  logic [7:0] op, sr, st;
  logic wel;
  int n;
  initial begin
    mem = '{16'h1234, 16'h0033, 16'h0015, 16'hC3A5};
    {op, sr, adr, dat, wel, rom_miso} = '0;
    n = 0;
  end
  always @(negedge rom_cs_n) n = 0;
  // ----
  // Bit capture on rising clock
  // ----
  always @(posedge rom_sck) begin
    if (n < 8) op = {op[6:0], rom_mosi};
    else if (n < 24) adr = {adr[14:0], rom_mosi};
    else dat = {dat[14:0], rom_mosi};
    if (op == 8'h01 && n >= 8 && n < 16) sr = {sr[6:0], rom_mosi};
    n++;
  end
  // Undriven output toggles so a stale level cannot pass for data
  always @(negedge rom_sck) begin
    st = {sr[7:2], wel, 1'b0};
    if (op == 8'h03 && n >= 24 && n < 40)
      rom_miso = mem[adr[1:0]][39-n];
    else if (op == 8'h05 && n >= 8 && n < 16) rom_miso = st[15-n];
    else rom_miso = ~rom_miso;
  end
  always @(posedge rom_cs_n) begin
    if (op == 8'h06) wel = 1'b1;
    if (op == 8'h04) wel = 1'b0;
    if (op == 8'h02 && n == 40 && wel) begin
      mem[adr[1:0]] = dat;
      wel = 1'b0;
    end
    rom_miso = ~rom_miso;
  end
endmodule // serial_rom_model

// >>> verification/testbench.sv
// Self-checking bench for the configuration register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, cfg_req, cfg_wr, cfg_ack, rom_miso;
  logic rom_sck, rom_cs_n, rom_mosi, refclk_buffer_powerdown_strap;
  logic [7:0] cfg_addr;
  logic [2:0] cfg_port;
  logic [3:0] cfg_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata, d, ex;
  logic [1:0] port_config;
  logic [6:0] refclk_output_enable, en;
  logic [9:0] ds_link_state;
  logic [4:0] pme_turnoff_req, gpio_out, gpio_oe, ds_reset_n;
  logic [15:0] opm, w16;
  logic [31:0] exp_q[$];
  int failures, checks_done;
  switch_port_config_eeprom_regs dut (.clk, .rst, .cfg_req, .cfg_wr,
    .cfg_addr, .cfg_port, .cfg_byte_en, .cfg_wdata, .cfg_ack, .cfg_rdata,
    .port_config, .refclk_buffer_powerdown_strap, .refclk_output_enable,
    .ds_link_state, .pme_turnoff_req, .gpio_out, .gpio_oe, .ds_reset_n,
    .rom_sck, .rom_cs_n, .rom_mosi, .rom_miso);
  serial_rom_model rom (.rom_sck, .rom_cs_n, .rom_mosi, .rom_miso);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop();
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [2:0] p,
                     input logic [3:0] b, input logic [31:0] v, e);
    @(posedge clk);
    #1;
    {cfg_req, cfg_wr, cfg_addr, cfg_port, cfg_byte_en} = {1'b1, w, a, p, b};
    cfg_wdata = v;
    exp_q.push_back(w ? 32'h0 : e);
    @(posedge clk);
    #1;
    cfg_req = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [2:0] p, input [31:0] e);
    acc(1'b0, a, p, 4'hF, 32'h0, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input [31:0] v);
    acc(1'b1, a, 3'h0, b, v, 32'h0);
  endtask
  // Measures one clock-high phase, then waits for the frame end
  task automatic wait_frame(input int hp = 32);
    int k, h;
    k = 0;
    h = 0;
    while (rom_cs_n !== 1'b0 && k < 300) begin @(negedge clk); k++; end
    while (rom_sck !== 1'b1 && k < 300) begin @(negedge clk); k++; end
    while (rom_sck === 1'b1 && h < 99) begin @(negedge clk); h++; end
    chk(32'(h), 32'(hp));
    while (rom_cs_n !== 1'b1 && k < 4000) begin @(negedge clk); k++; end
    chk(32'(k < 4000), 32'h1);
  endtask
  task automatic cmd(input logic [2:0] c);
    wr(8'hA0, 4'h1, {24'h0, 4'h4, c, 1'b1});
    wait_frame();
  endtask
  always @(negedge clk) if (cfg_ack === 1'b1) begin
    ex = exp_q.pop_front();
    chk(cfg_rdata, ex);
  end
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    {rst, cfg_req, cfg_wr, cfg_addr, cfg_port, cfg_byte_en} = 18'h20000;
    {cfg_wdata, port_config, ds_link_state} = '0;
    refclk_buffer_powerdown_strap = 1'b0;
    d = $urandom(91);
    port_config = 2'($urandom % 4);
    refclk_buffer_powerdown_strap = 1'($urandom % 2);
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    opm = port_config == 1 ? 16'h01E2 :
          port_config == 2 ? 16'h01C2 : 16'h0182;
    en = port_config == 1 ? 7'h7F : 7'h5F;
    chk(32'(refclk_output_enable),
        refclk_buffer_powerdown_strap ? 32'h0 : 32'(en));
    chk(32'({pme_turnoff_req, gpio_out, gpio_oe, ds_reset_n}),
        32'h07FFF);
    rd(8'h94, 3'h0, 32'h116B);
    wr(8'h94, 4'hF, 32'hFFFFFFFF);
    rd(8'h94, 3'h0, 32'h116B);
    rd(8'h98, 3'h0, {8'h0, refclk_buffer_powerdown_strap, en, opm});
    rd(8'hA0, 3'h0, 32'h60);
    rd(8'hB0, 3'h0, 32'h0);
    rd(8'h94, 3'h1, 32'h0);
    wr(8'hA0, 4'h2, 32'hFFFF);
    rd(8'hA0, 3'h0, 32'h8C60);
    d = $urandom;
    wr(8'hA4, 4'hF, d);
    rd(8'hA4, 3'h0, d);
    for (int p = 1; p <= 5; p++) begin
      ds_link_state = 10'($urandom);
      ds_link_state[2*p-2 +: 2] = 2'(p);
      d = $urandom;
      acc(1'b1, 8'h9C, 3'(p), 4'h1, d, 32'h0);
      rd(8'h9C, 3'(p), {14'h0, 2'(p), 12'h0, d[3:1], 1'b1});
      chk(32'({ds_reset_n[p-1], gpio_out[p-1], pme_turnoff_req[p-1]}),
          32'(d[3:1]));
    end
    wr(8'hA0, 4'h1, 32'h40);
    repeat (3) wait_frame();
    rd(8'hA0, 3'h0, 32'h8C50);
    rd(8'h94, 3'h0, 32'h1234);
    rd(8'h98, 3'h0, {9'h0, 7'h33, opm});
    chk(32'({refclk_output_enable, gpio_oe}), 32'h675);
    cmd(3'h6);
    rd(8'hA0, 3'h0, 32'h8C5C);
    cmd(3'h5);
    rd(8'hA0, 3'h0, 32'h8E5A);
    w16 = 16'($urandom);
    wr(8'hA4, 4'hF, {w16, 16'h0002});
    cmd(3'h2);
    wr(8'hA4, 4'hF, 32'h2);
    wr(8'hA0, 4'h1, 32'h47);
    wr(8'hA0, 4'h1, 32'h4D);
    wait_frame();
    repeat (5) @(negedge clk);
    chk(32'(rom_cs_n), 32'h1);
    rd(8'hA4, 3'h0, {w16, 16'h0002});
    rd(8'hA0, 3'h0, 32'h8E56);
    cmd(3'h4);
    cmd(3'h5);
    rd(8'hA0, 3'h0, 32'h8C5A);
    cmd(3'h1);
    chk(32'(rom.sr), 32'h8C);
    wr(8'hA0, 4'h1, 32'h4F);
    rd(8'hA0, 3'h0, 32'h8C5E);
    chk(32'(rom_cs_n), 32'h1);
    wr(8'hA0, 4'h1, 32'hCD);
    wait_frame(1);
    rd(8'hA0, 3'h0, 32'h8CDC);
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule // testbench
